// ==== hdl/bstp_pkg.sv ====
package bstp_pkg;

    // ------------------------------------------------------------
    // Widths and codes
    // ------------------------------------------------------------
    localparam int IR_W = 3;
    localparam int CHAIN_W = 58;
    localparam int PAD_W = 57;
    localparam int TOP_CELLS = 3;
    localparam logic [2:0] IR_RESET = 3'h7;
    localparam logic [2:0] IR_CAPTURE = 3'h4;
    localparam logic [2:0] IR_EXTERNAL = 3'h0;
    localparam logic [2:0] IR_CACHE_TEST = 3'h3;
    localparam int OE_CELL = 57;
    localparam int RESET_TMS_EDGES = 5;

    // ------------------------------------------------------------
    // Controller states, Gray-coded along the main paths
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_IDLE = 4'h1,
        ST_SEL_DR = 4'h3,
        ST_CAP_DR = 4'h2,
        ST_SH_DR = 4'h6,
        ST_EX1_DR = 4'h7,
        ST_PAU_DR = 4'h5,
        ST_EX2_DR = 4'h4,
        ST_UPD_DR = 4'hC,
        ST_SEL_IR = 4'hD,
        ST_CAP_IR = 4'hF,
        ST_SH_IR = 4'hE,
        ST_EX1_IR = 4'hA,
        ST_PAU_IR = 4'hB,
        ST_EX2_IR = 4'h9,
        ST_UPD_IR = 4'h8
    } bstp_state_t;

endpackage : bstp_pkg

// ==== hdl/bstp_sync.sv ====
module bstp_sync
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    // ------------------------------------------------------------
    // Two-flop synchroniser for pins
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic s1_r;
        logic s2_r;
    } bstp_sync_t;

    bstp_sync_t st_r;
    bstp_sync_t st_nxt;

    // Only the second stage is looked at outside
    always_comb
    begin
        st_nxt.s1_r = d;
        st_nxt.s2_r = st_r.s1_r;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign q = st_r.s2_r;
endmodule : bstp_sync

// ==== hdl/bstp_tap_fsm.sv ====
module bstp_tap_fsm
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tck_rise,
    input wire logic tms,
    output bstp_pkg::bstp_state_t state
);
    // ------------------------------------------------------------
    // Sixteen-state controller, stepped on test-clock rising edges
    // ------------------------------------------------------------
    typedef struct packed
    {
        bstp_pkg::bstp_state_t state_r;
    } bstp_fsm_t;

    bstp_fsm_t st_r;
    bstp_fsm_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (tck_rise)
        begin
            case (st_r.state_r)
                bstp_pkg::ST_RESET: st_nxt.state_r = tms ? bstp_pkg::ST_RESET : bstp_pkg::ST_IDLE;
                bstp_pkg::ST_IDLE: st_nxt.state_r = tms ? bstp_pkg::ST_SEL_DR : bstp_pkg::ST_IDLE;
                bstp_pkg::ST_SEL_DR: st_nxt.state_r = tms ? bstp_pkg::ST_SEL_IR : bstp_pkg::ST_CAP_DR;
                bstp_pkg::ST_CAP_DR: st_nxt.state_r = tms ? bstp_pkg::ST_EX1_DR : bstp_pkg::ST_SH_DR;
                bstp_pkg::ST_SH_DR: st_nxt.state_r = tms ? bstp_pkg::ST_EX1_DR : bstp_pkg::ST_SH_DR;
                bstp_pkg::ST_EX1_DR: st_nxt.state_r = tms ? bstp_pkg::ST_UPD_DR : bstp_pkg::ST_PAU_DR;
                bstp_pkg::ST_PAU_DR: st_nxt.state_r = tms ? bstp_pkg::ST_EX2_DR : bstp_pkg::ST_PAU_DR;
                bstp_pkg::ST_EX2_DR: st_nxt.state_r = tms ? bstp_pkg::ST_UPD_DR : bstp_pkg::ST_SH_DR;
                bstp_pkg::ST_UPD_DR: st_nxt.state_r = tms ? bstp_pkg::ST_SEL_DR : bstp_pkg::ST_IDLE;
                bstp_pkg::ST_SEL_IR: st_nxt.state_r = tms ? bstp_pkg::ST_RESET : bstp_pkg::ST_CAP_IR;
                bstp_pkg::ST_CAP_IR: st_nxt.state_r = tms ? bstp_pkg::ST_EX1_IR : bstp_pkg::ST_SH_IR;
                bstp_pkg::ST_SH_IR: st_nxt.state_r = tms ? bstp_pkg::ST_EX1_IR : bstp_pkg::ST_SH_IR;
                bstp_pkg::ST_EX1_IR: st_nxt.state_r = tms ? bstp_pkg::ST_UPD_IR : bstp_pkg::ST_PAU_IR;
                bstp_pkg::ST_PAU_IR: st_nxt.state_r = tms ? bstp_pkg::ST_EX2_IR : bstp_pkg::ST_PAU_IR;
                bstp_pkg::ST_EX2_IR: st_nxt.state_r = tms ? bstp_pkg::ST_UPD_IR : bstp_pkg::ST_SH_IR;
                bstp_pkg::ST_UPD_IR: st_nxt.state_r = tms ? bstp_pkg::ST_SEL_DR : bstp_pkg::ST_IDLE;
                default: st_nxt.state_r = bstp_pkg::ST_RESET;
            endcase
        end
    end

    // Cold reset forces the reset state without any test-clock edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_r.state_r <= bstp_pkg::ST_RESET;
        else
            st_r <= st_nxt;
    end

    assign state = st_r.state_r;
endmodule : bstp_tap_fsm

// ==== hdl/bstp_top.sv ====
module bstp_top
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic TEST_SHIFT_CLOCK,
    input wire logic TEST_STATE_SELECT,
    input wire logic TEST_SERIAL_IN,
    output logic TEST_SERIAL_OUT,
    output logic TEST_SERIAL_OUT_OE,
    input wire logic [56:0] PAD_LEVELS,
    output logic [56:0] PAD_SCAN_VALUES,
    output logic SCAN_OUTPUT_ENABLE_CELL,
    output logic [2:0] SCAN_TOP_CELLS,
    output logic EXTERNAL_TEST_ACTIVE,
    output logic CACHE_TEST_FLAG
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic [56:0] pads_s;
    bstp_pkg::bstp_state_t state;

    bstp_sync u_sync_tck (.clk(CLK), .rst_n(RST_N), .d(TEST_SHIFT_CLOCK), .q(tck_s));
    bstp_sync u_sync_tms (.clk(CLK), .rst_n(RST_N), .d(TEST_STATE_SELECT), .q(tms_s));
    bstp_sync u_sync_tdi (.clk(CLK), .rst_n(RST_N), .d(TEST_SERIAL_IN), .q(tdi_s));

    // Pad levels pass through the same two stages, one per pad
    genvar gi;
    generate
        for (gi = 0; gi < bstp_pkg::PAD_W; gi++)
        begin : g_pad_sync
            bstp_sync u_sync_pad (.clk(CLK), .rst_n(RST_N), .d(PAD_LEVELS[gi]), .q(pads_s[gi]));
        end
    endgenerate

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic tck_r;
        logic [2:0] ir_shift_r;
        logic [2:0] ir_latch_r;
        logic bypass_r;
        logic [57:0] chain_r;
        logic [57:0] chain_upd_r;
        logic upd_pend_r;
        logic tdo_r;
        logic tdo_oe_r;
        logic cache_flag_r;
    } bstp_top_t;

    bstp_top_t st_r;
    bstp_top_t st_nxt;
    logic tck_rise;
    logic tck_fall;

    // Edge detection only on the second synchroniser stage
    assign tck_rise = tck_s & ~st_r.tck_r;
    assign tck_fall = ~tck_s & st_r.tck_r;

    bstp_tap_fsm u_fsm
    (
        .clk(CLK),
        .rst_n(RST_N),
        .tck_rise(tck_rise),
        .tms(tms_s),
        .state(state)
    );

    // Chain selected only for code zero; the rest is bypass
    function automatic logic chain_sel(input logic [2:0] code);
        chain_sel = (code == bstp_pkg::IR_EXTERNAL);
    endfunction : chain_sel

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.tck_r = tck_s;
        if (tck_rise)
        begin
            // Pending update lands two rising edges after entering update
            if (st_r.upd_pend_r)
            begin
                st_nxt.chain_upd_r = st_r.chain_r;
                st_nxt.upd_pend_r = 1'b0;
            end
            case (state)
                bstp_pkg::ST_RESET:
                begin
                    st_nxt.ir_latch_r = bstp_pkg::IR_RESET;
                    st_nxt.chain_r[57:55] = 3'h0;
                    st_nxt.chain_upd_r[57:55] = 3'h0;
                    st_nxt.upd_pend_r = 1'b0;
                end
                bstp_pkg::ST_CAP_IR:
                    st_nxt.ir_shift_r = bstp_pkg::IR_CAPTURE;
                bstp_pkg::ST_SH_IR:
                    st_nxt.ir_shift_r = {st_r.ir_shift_r[1:0], tdi_s};
                bstp_pkg::ST_UPD_IR:
                    st_nxt.ir_latch_r = st_r.ir_shift_r;
                bstp_pkg::ST_CAP_DR:
                begin
                    // Output-only pad cells capture whatever the pad reads back
                    if (chain_sel(st_r.ir_latch_r))
                        st_nxt.chain_r[56:0] = pads_s;
                end
                bstp_pkg::ST_SH_DR:
                begin
                    if (chain_sel(st_r.ir_latch_r))
                        st_nxt.chain_r = {st_r.chain_r[56:0], tdi_s};
                    else
                        st_nxt.bypass_r = tdi_s;
                end
                bstp_pkg::ST_UPD_DR:
                    st_nxt.upd_pend_r = chain_sel(st_r.ir_latch_r);
                default:
                    st_nxt.upd_pend_r = st_r.upd_pend_r & ~st_r.upd_pend_r;
            endcase
        end
        // Sticky flag: set whenever the latched code is 011
        if (st_r.ir_latch_r == bstp_pkg::IR_CACHE_TEST)
            st_nxt.cache_flag_r = 1'b1;
        // Serial out moves only on falling edges
        if (tck_fall)
        begin
            case (state)
                bstp_pkg::ST_SH_IR:
                begin
                    st_nxt.tdo_r = st_r.ir_shift_r[2];
                    st_nxt.tdo_oe_r = 1'b1;
                end
                bstp_pkg::ST_SH_DR:
                begin
                    st_nxt.tdo_r = chain_sel(st_r.ir_latch_r) ? st_r.chain_r[57]
                                                              : st_r.bypass_r;
                    st_nxt.tdo_oe_r = 1'b1;
                end
                default:
                begin
                    st_nxt.tdo_r = 1'b0;
                    st_nxt.tdo_oe_r = 1'b0;
                end
            endcase
        end
    end

    // Output enable cell comes up as 1 on cold reset, until the first test-clock rise in the reset state clears it to 0
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            st_r <= '0;
            st_r.ir_latch_r <= bstp_pkg::IR_RESET;
            st_r.chain_upd_r[bstp_pkg::OE_CELL] <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign TEST_SERIAL_OUT = st_r.tdo_r;
    assign TEST_SERIAL_OUT_OE = st_r.tdo_oe_r;
    assign PAD_SCAN_VALUES = st_r.chain_upd_r[56:0];
    assign SCAN_OUTPUT_ENABLE_CELL = st_r.chain_upd_r[bstp_pkg::OE_CELL];
    assign SCAN_TOP_CELLS = st_r.chain_upd_r[57:55];
    assign EXTERNAL_TEST_ACTIVE = chain_sel(st_r.ir_latch_r);
    assign CACHE_TEST_FLAG = st_r.cache_flag_r;
endmodule : bstp_top

// ==== tb/bstp_chk_sva.sv ====
module bstp_chk
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic TEST_SHIFT_CLOCK,
    input wire logic TEST_STATE_SELECT,
    input wire logic TEST_SERIAL_OUT,
    input wire logic TEST_SERIAL_OUT_OE,
    input wire logic [56:0] PAD_SCAN_VALUES,
    input wire logic SCAN_OUTPUT_ENABLE_CELL,
    input wire logic [2:0] SCAN_TOP_CELLS,
    input wire logic EXTERNAL_TEST_ACTIVE,
    input wire logic CACHE_TEST_FLAG
);
    // ----
    // Test-clock rises seen with mode select high
    // ----
    logic tck_r;
    logic [2:0] hi_r;
    // Saturates at 7 so a long hold never wraps
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            tck_r <= 1'h0;
            hi_r <= 3'h0;
        end
        else
        begin
            tck_r <= TEST_SHIFT_CLOCK;
            if (TEST_SHIFT_CLOCK && !tck_r)
                hi_r <= TEST_STATE_SELECT ? hi_r + {2'h0, hi_r != 3'h7} : 3'h0;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // Sync delay is two clocks, so edge checks look two back
    oe_cell_top_a:
        assert property (SCAN_OUTPUT_ENABLE_CELL == SCAN_TOP_CELLS[2]) else $error("enable cell");
    flag_sticky_a:
        assert property (CACHE_TEST_FLAG |=> CACHE_TEST_FLAG) else $error("flag dropped");
    flag_not_ext_a:
        assert property ($rose(CACHE_TEST_FLAG) |-> !EXTERNAL_TEST_ACTIVE) else $error("flag ext");
    tdo_on_fall_a:
        assert property ($changed(TEST_SERIAL_OUT) |-> !$past(TEST_SHIFT_CLOCK)
            && !$past(TEST_SHIFT_CLOCK, 2)) else $error("serial out moved off fall");
    oe_on_fall_a:
        assert property ($changed(TEST_SERIAL_OUT_OE) |-> !$past(TEST_SHIFT_CLOCK)
            && !$past(TEST_SHIFT_CLOCK, 2)) else $error("enable moved off fall");
    update_on_rise_a:
        assert property ($changed(PAD_SCAN_VALUES) |-> $past(TEST_SHIFT_CLOCK)
            && $past(TEST_SHIFT_CLOCK, 2)) else $error("update off rise");
    tms_reset_a:
        assert property (hi_r == 3'h6 |-> ##3 !EXTERNAL_TEST_ACTIVE && SCAN_TOP_CELLS == 3'h0)
            else $error("mode select reset");
    cold_reset_a:
        assert property (disable iff (1'b0) !RST_N |-> !TEST_SERIAL_OUT_OE
            && !EXTERNAL_TEST_ACTIVE && SCAN_TOP_CELLS == 3'h4) else $error("cold reset");
endmodule : bstp_chk

bind bstp_top bstp_chk chk_u (.CLK, .RST_N, .TEST_SHIFT_CLOCK, .TEST_STATE_SELECT,
    .TEST_SERIAL_OUT, .TEST_SERIAL_OUT_OE, .PAD_SCAN_VALUES, .SCAN_OUTPUT_ENABLE_CELL,
    .SCAN_TOP_CELLS, .EXTERNAL_TEST_ACTIVE, .CACHE_TEST_FLAG);

// ==== tb/bstp_ctl.sv ====
module bstp_ctl
(
    input wire logic clk,
    input wire logic tdo,
    input wire logic tdo_oe,
    output logic tck,
    output logic tms,
    output logic tdi
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last_r = 1'h0;
    logic tdo_w;
    // Released line shows the inverse, so a stale bit never passes
    assign tdo_w = tdo_oe ? tdo : ~last_r;
    always @(posedge clk)
        if (tdo_oe)
            last_r <= tdo;
    initial
    begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h0;
    end
    // One test-clock period: 4 clocks low, 4 high; out sampled before fall
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        repeat (4) @(posedge clk);
        #5 tck = 1'h1;
        repeat (4) @(posedge clk);
        #5 q = tdo_w;
        tck = 1'h0;
    endtask : step
    // Idle to idle scan of n bits, first sent bit lands at the top
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
        output logic [63:0] dout);
        logic b;
        b = 1'h0;
        dout = 64'h0;
        step(1'h1, b, b);
        if (ir)
            step(1'h1, b, b);
        step(1'h0, b, b);
        step(1'h0, b, b);
        for (int i = n - 1; i >= 0; i--)
        begin
            step(i == 0, din[i], b);
            dout[i] = b;
        end
        step(1'h1, b, b);
        step(1'h0, b, b);
        // Chain update lands one rise after update, so give it one idle rise
        step(1'h0, b, b);
    endtask : scan
    task automatic treset;
        logic b;
        b = 1'h0;
        repeat (6) step(1'h1, b, b);
        step(1'h0, b, b);
    endtask : treset
endmodule : bstp_ctl

// ==== tb/tb_bstp_top.sv ====
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin err_total++; \
    $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module tb_bstp_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 1'h0;
    logic RST_N = 1'h1;
    logic [56:0] PAD_LEVELS = 57'h0;
    logic TEST_SHIFT_CLOCK, TEST_STATE_SELECT, TEST_SERIAL_IN, TEST_SERIAL_OUT;
    logic TEST_SERIAL_OUT_OE, SCAN_OUTPUT_ENABLE_CELL, EXTERNAL_TEST_ACTIVE, CACHE_TEST_FLAG;
    logic [56:0] PAD_SCAN_VALUES;
    logic [2:0] SCAN_TOP_CELLS;
    logic [63:0] d, r, din;
    int err_total = 0;
    int checks = 0;
    // Clock, 100 ns period
    always #50 CLK = ~CLK;
    bstp_top dut_u (.CLK, .RST_N, .TEST_SHIFT_CLOCK, .TEST_STATE_SELECT, .TEST_SERIAL_IN,
        .TEST_SERIAL_OUT, .TEST_SERIAL_OUT_OE, .PAD_LEVELS, .PAD_SCAN_VALUES,
        .SCAN_OUTPUT_ENABLE_CELL, .SCAN_TOP_CELLS, .EXTERNAL_TEST_ACTIVE, .CACHE_TEST_FLAG);
    bstp_ctl ctl_u (.clk(CLK), .tdo(TEST_SERIAL_OUT), .tdo_oe(TEST_SERIAL_OUT_OE),
        .tck(TEST_SHIFT_CLOCK), .tms(TEST_STATE_SELECT), .tdi(TEST_SERIAL_IN));
    // Codes are loaded in rising order, so the flag is set from code 3 on
    function automatic logic flag_exp(input int code);
        return code >= int'(bstp_pkg::IR_CACHE_TEST);
    endfunction : flag_exp
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    // Main sequence
    initial
    begin
        void'($urandom(45));
        #1 RST_N = 1'h0;
        repeat (20) @(posedge CLK);
        #5 RST_N = 1'h1;
        `CHK("top", 3'h4, SCAN_TOP_CELLS)
        `CHK("oe", 1'h0, TEST_SERIAL_OUT_OE)
        repeat (3) @(posedge CLK);
        #5 ctl_u.treset();
        ctl_u.scan(1'h1, 3, 64'h0, d);
        `CHK("ir_cap", bstp_pkg::IR_CAPTURE, d[2:0])
        `CHK("ext", 1'h1, EXTERNAL_TEST_ACTIVE)
        $display("test reset_ir done");
        for (int c = 1; c < 8; c++)
        begin
            ctl_u.scan(1'h1, 3, 64'(c), d);
            `CHK("ext", 1'h0, EXTERNAL_TEST_ACTIVE)
            `CHK("flag", flag_exp(c), CACHE_TEST_FLAG)
            r = {$urandom, $urandom};
            ctl_u.scan(1'h0, 20, r, d);
            `CHK("byp", r[19:1], d[18:0])
        end
        $display("test bypass done");
        for (int i = 0; i < 3; i++)
        begin
            ctl_u.scan(1'h1, 3, 64'h0, d);
            PAD_LEVELS = 57'({$urandom, $urandom});
            din = (i == 0) ? '1 : {$urandom, $urandom};
            ctl_u.scan(1'h0, 58, din, d);
            `CHK("pads", PAD_LEVELS, d[56:0])
            `CHK("upd", din[56:0], PAD_SCAN_VALUES)
            `CHK("top", din[57:55], SCAN_TOP_CELLS)
        end
        $display("test extest done");
        ctl_u.treset();
        `CHK("ext", 1'h0, EXTERNAL_TEST_ACTIVE)
        `CHK("top", 3'h0, SCAN_TOP_CELLS)
        `CHK("low", din[54:0], PAD_SCAN_VALUES[54:0])
        $display("test tms_reset done");
        ctl_u.scan(1'h1, 3, 64'h0, d);
        @(posedge CLK);
        #5 RST_N = 1'h0;
        repeat (2) @(posedge CLK);
        #5 `CHK("ext", 1'h0, EXTERNAL_TEST_ACTIVE)
        `CHK("flag", 1'h0, CACHE_TEST_FLAG)
        RST_N = 1'h1;
        repeat (3) @(posedge CLK);
        #5 ctl_u.treset();
        r = {$urandom, $urandom};
        ctl_u.scan(1'h0, 8, r, d);
        `CHK("byp", r[7:1], d[6:0])
        $display("test cold_reset done");
        give_verdict();
    end
    // Watchdog, several times the expected run length
    initial
    begin
        #2000000;
        err_total++;
        give_verdict();
    end
endmodule : tb_bstp_top
